// ### core/pscr_cfg.svh
// Offsets, page codes, state codes and timing constants of the paged register logic
`ifndef PSCR_CFG_SVH
`define PSCR_CFG_SVH

// Register offsets, identical on every page that holds them
`define PG_SEL_OFS 8'hFF
`define STATE_RD_OFS 8'hD0
`define STATE_SEL_OFS 8'hD1
`define COMMIT_OFS 8'hC0
`define POWER_EN_OFS 8'hE1
`define LIVE_A_OFS 8'h02
`define STICKY_A_OFS 8'h03
`define MASK_A_OFS 8'h04
`define LIVE_B_OFS 8'h06
`define STICKY_B_OFS 8'h07
`define MASK_B_OFS 8'h08

// Page numbers
`define PG_MASTER 8'h00
`define PG_MONITOR 8'h01
`define PG_INPUT 8'h02
`define PG_OUTPUT 8'h03
`define PG_PLL_A 8'h0A
`define PG_PLL_B 8'h0B
`define PG_PLL_C 8'h0C
`define PG_PLL_D 8'h0D

// Internal subsystem indices
`define IDX_MASTER 3'h0
`define IDX_MONITOR 3'h1
`define IDX_INPUT 3'h2
`define IDX_OUTPUT 3'h3
`define IDX_PLL_A 3'h4
`define IDX_PLL_B 3'h5
`define IDX_PLL_C 3'h6
`define IDX_PLL_D 3'h7

// State-select keys expected in the select register
`define SEL_KEY_MAIN 8'h40
`define SEL_KEY_OUTPUT 8'h60
`define SEL_KEY_PLL 8'h20

// State readback codes
`define CODE_IDLE 8'h00
`define CODE_MST_WAIT 8'h09
`define CODE_MST_ACT 8'h24
`define CODE_MON_WAIT 8'h05
`define CODE_MON_ACT 8'h0C
`define CODE_INP_WAIT 8'h07
`define CODE_INP_ACT 8'h17
`define CODE_OUT_WAIT 8'h0C
`define CODE_OUT_ACT 8'h14
`define CODE_PLL_WAIT 8'h08
`define CODE_PLL_ACT 8'h30

// Field positions, keys and reset values
`define OSC_LOSS_BIT 2
`define PLL_LOL_BIT 0
`define COMMIT_KEY 8'h01
`define PAGE_RST 8'h00
`define BYTE_RST 8'h00
`define POWER_RST 7'h00
`define LOAD_CNT_RST 16'h0000

// Timing
`define CLK_PERIOD_NS 4
`define NVM_LOAD_NS 1000

`endif

// ### core/pscr_pkg.sv
// Types shared by the paged status and init control logic
package pscr_pkg;

   // Subsystem state machine, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_WAIT = 3'h2,
      ST_ACTIVE = 3'h4
   } subsys_state_e;

   // One register access from the serial port front end
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   // Live conditions from the analog side
   typedef struct packed {
      logic osc_loss;
      logic [3:0] pll_unlocked;
      logic [3:0] pll_holdover;
      logic [3:0] in_clk_loss;
      logic [3:0] drift_fine;
      logic [3:0] drift_coarse;
   } live_s;

endpackage

// ### core/sticky_bank.sv
// Bank of masked sticky notify bits, cleared by writing ones
`timescale 1ns/10ps
`default_nettype none
module sticky_bank #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Events, enables and clears
   input wire logic [W-1:0] i_event,
   input wire logic [W-1:0] i_mask,
   input wire logic [W-1:0] i_clear,
   // Flags
   output logic [W-1:0] o_flags
);

   logic [W-1:0] flags_reg;
   logic [W-1:0] flags_next;

   // Set wins over a clear in the same cycle so no event is lost
   assign flags_next = (flags_reg & ~i_clear) | (i_event & i_mask);

   // Flag storage
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         flags_reg <= '0;
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign o_flags = flags_reg;

endmodule // sticky_bank
`default_nettype wire

// ### core/subsys_state_fsm.sv
// Idle, program-command wait and active state machine of one subsystem
`timescale 1ns/10ps
`default_nettype none
module subsys_state_fsm
   import pscr_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Control
   input wire logic i_enable,
   input wire logic i_auto,
   input wire logic i_commit,
   // State
   output subsys_state_e o_state
);

   subsys_state_e state_reg;
   subsys_state_e state_next;

   // Without stored configuration it parks in wait until the host commits
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (i_enable) begin
               state_next = i_auto ? ST_ACTIVE : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!i_enable) begin
               state_next = ST_IDLE;
            end else if (i_commit) begin
               state_next = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (!i_enable) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_state = state_reg;

endmodule // subsys_state_fsm
`default_nettype wire

// ### core/paged_status_and_init_control.sv
// Paged control and status registers of a multi-PLL clock device
`timescale 1ns/10ps
`default_nettype none
`include "pscr_cfg.svh"
module paged_status_and_init_control
   import pscr_pkg::*;
(
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RESET,
   // Register access from the serial port front end
   input wire reg_req_s i_REG_REQ,
   output logic [7:0] o_RD_DATA,
   output logic o_RD_VALID,
   // Analog side status pins
   input wire live_s i_LIVE,
   input wire logic i_NVM_PROGRAMMED,
   // Notify and subsystem power
   output logic o_NOTIFY,
   output logic [6:0] o_SUBSYS_POWER
);

   localparam int LOAD_CYC_INT = (`NVM_LOAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam logic [15:0] LOAD_CYC = 16'(LOAD_CYC_INT);

   // Page number to {valid, index}
   function automatic logic [3:0] page_decode(input logic [7:0] page);
      logic [3:0] res;
      res = 4'h0;
      case (page)
         `PG_MASTER: res = {1'b1, `IDX_MASTER};
         `PG_MONITOR: res = {1'b1, `IDX_MONITOR};
         `PG_INPUT: res = {1'b1, `IDX_INPUT};
         `PG_OUTPUT: res = {1'b1, `IDX_OUTPUT};
         `PG_PLL_A: res = {1'b1, `IDX_PLL_A};
         `PG_PLL_B: res = {1'b1, `IDX_PLL_B};
         `PG_PLL_C: res = {1'b1, `IDX_PLL_C};
         `PG_PLL_D: res = {1'b1, `IDX_PLL_D};
         default: res = 4'h0;
      endcase
      return res;
   endfunction

   // Select key that unlocks the state readback of a subsystem
   function automatic logic [7:0] sel_key(input logic [2:0] idx);
      logic [7:0] key;
      key = `SEL_KEY_PLL;
      if (idx == `IDX_OUTPUT) begin
         key = `SEL_KEY_OUTPUT;
      end else if (!idx[2]) begin
         key = `SEL_KEY_MAIN;
      end
      return key;
   endfunction

   // Readback code of a subsystem in a given state
   function automatic logic [7:0] state_code(input logic [2:0] idx, input subsys_state_e st);
      logic [7:0] wait_c;
      logic [7:0] act_c;
      logic [7:0] code;
      wait_c = `CODE_PLL_WAIT;
      act_c = `CODE_PLL_ACT;
      case (idx)
         `IDX_MASTER: begin
            wait_c = `CODE_MST_WAIT;
            act_c = `CODE_MST_ACT;
         end
         `IDX_MONITOR: begin
            wait_c = `CODE_MON_WAIT;
            act_c = `CODE_MON_ACT;
         end
         `IDX_INPUT: begin
            wait_c = `CODE_INP_WAIT;
            act_c = `CODE_INP_ACT;
         end
         `IDX_OUTPUT: begin
            wait_c = `CODE_OUT_WAIT;
            act_c = `CODE_OUT_ACT;
         end
         default: begin
            wait_c = `CODE_PLL_WAIT;
            act_c = `CODE_PLL_ACT;
         end
      endcase
      code = `CODE_IDLE;
      if (st == ST_WAIT) begin
         code = wait_c;
      end else if (st == ST_ACTIVE) begin
         code = act_c;
      end
      return code;
   endfunction

   // Synchroniser stages for the asynchronous status pins
   live_s live_meta_reg;
   live_s live_reg;
   logic nvm_meta_reg;
   logic nvm_reg;

   // Control and status storage
   logic [7:0] page_reg;
   logic [7:0] sel_reg [8];
   logic mst_osc_mask_reg;
   logic [7:0] mst_lolho_mask_reg;
   logic [3:0] mon_cl_mask_reg;
   logic [7:0] mon_drift_mask_reg;
   logic [7:0] pll_mask_reg [4];
   logic [6:0] power_reg;
   logic [15:0] load_cnt_reg;
   logic load_done_reg;
   logic [7:0] rd_data_reg;
   logic rd_valid_reg;
   logic notify_reg;

   // Decoded request
   logic wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [3:0] pg_dec;
   logic pg_valid;
   logic [2:0] pg_idx;
   logic on_master;
   logic on_monitor;
   logic on_pll;
   logic [1:0] pll_sel;
   logic wr_page;
   logic wr_paged;
   logic wr_sel;
   logic wr_commit;
   logic [7:0] commit_vec;

   // Sticky banks
   logic osc_clr;
   logic [7:0] lolho_clr;
   logic [3:0] cl_clr;
   logic [7:0] drift_clr;
   logic [3:0] pll_clr;
   logic [3:0] pll_lol_mask;
   logic [0:0] osc_flag;
   logic [7:0] lolho_flags;
   logic [3:0] cl_flags;
   logic [7:0] drift_flags;
   logic [3:0] pll_flags;

   // Subsystem states
   subsys_state_e st [8];
   logic [7:0] st_enable;
   logic [7:0] rd_next;
   logic sel_ok;

   // Two flops on every status pin before any logic reads it
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         live_meta_reg <= '0;
         live_reg <= '0;
         nvm_meta_reg <= 1'b0;
         nvm_reg <= 1'b0;
      end else begin
         live_meta_reg <= i_LIVE;
         live_reg <= live_meta_reg;
         nvm_meta_reg <= i_NVM_PROGRAMMED;
         nvm_reg <= nvm_meta_reg;
      end
   end

   // Request decode against the current page
   assign wr = i_REG_REQ.wr;
   assign addr = i_REG_REQ.addr;
   assign wdata = i_REG_REQ.wdata;
   assign pg_dec = page_decode(page_reg);
   assign pg_valid = pg_dec[3];
   assign pg_idx = pg_dec[2:0];
   assign on_master = pg_valid && (pg_idx == `IDX_MASTER);
   assign on_monitor = pg_valid && (pg_idx == `IDX_MONITOR);
   assign on_pll = pg_valid && pg_idx[2];
   assign pll_sel = pg_idx[1:0];
   assign wr_page = wr && (addr == `PG_SEL_OFS);
   assign wr_paged = wr && pg_valid && (addr != `PG_SEL_OFS);
   assign wr_sel = wr_paged && (addr == `STATE_SEL_OFS);
   assign wr_commit = wr_paged && (addr == `COMMIT_OFS) && (wdata == `COMMIT_KEY);
   assign commit_vec = wr_commit ? (8'h01 << pg_idx) : 8'h00;

   // Write-one clears; a zero bit leaves its flag alone
   assign osc_clr = (on_master && wr && addr == `STICKY_A_OFS) ? wdata[`OSC_LOSS_BIT] : 1'b0;
   assign lolho_clr = (on_master && wr && addr == `STICKY_B_OFS) ? wdata : 8'h00;
   assign cl_clr = (on_monitor && wr && addr == `STICKY_A_OFS) ? wdata[3:0] : 4'h0;
   assign drift_clr = (on_monitor && wr && addr == `STICKY_B_OFS) ? wdata : 8'h00;
   assign pll_clr = (on_pll && wr && addr == `STICKY_A_OFS && wdata[`PLL_LOL_BIT]) ?
                    (4'h1 << pll_sel) : 4'h0;
   assign pll_lol_mask = {pll_mask_reg[3][`PLL_LOL_BIT], pll_mask_reg[2][`PLL_LOL_BIT],
                          pll_mask_reg[1][`PLL_LOL_BIT], pll_mask_reg[0][`PLL_LOL_BIT]};

   // Page select takes effect at the edge that completes the write
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         page_reg <= `PAGE_RST;
      end else if (wr_page) begin
         page_reg <= wdata;
      end
   end

   // Per-page state-select registers
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         for (int i = 0; i < 8; i++) begin
            sel_reg[i] <= `BYTE_RST;
         end
      end else if (wr_sel) begin
         sel_reg[pg_idx] <= wdata;
      end
   end

   // Mask and power registers on the master and monitor pages
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         mst_osc_mask_reg <= 1'b0;
         mst_lolho_mask_reg <= `BYTE_RST;
         mon_cl_mask_reg <= 4'h0;
         mon_drift_mask_reg <= `BYTE_RST;
         power_reg <= `POWER_RST;
      end else if (wr) begin
         if (on_master && addr == `MASK_A_OFS) mst_osc_mask_reg <= wdata[`OSC_LOSS_BIT];
         if (on_master && addr == `MASK_B_OFS) mst_lolho_mask_reg <= wdata;
         if (on_master && addr == `POWER_EN_OFS) power_reg <= wdata[6:0];
         if (on_monitor && addr == `MASK_A_OFS) mon_cl_mask_reg <= wdata[3:0];
         if (on_monitor && addr == `MASK_B_OFS) mon_drift_mask_reg <= wdata;
      end
   end

   // Per-PLL notify masks
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         for (int i = 0; i < 4; i++) begin
            pll_mask_reg[i] <= `BYTE_RST;
         end
      end else if (on_pll && wr && addr == `MASK_A_OFS) begin
         pll_mask_reg[pll_sel] <= wdata;
      end
   end

   // Configuration load window after reset; nothing answers as ready before it
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         load_cnt_reg <= `LOAD_CNT_RST;
         load_done_reg <= 1'b0;
      end else if (!load_done_reg) begin
         load_cnt_reg <= load_cnt_reg + 16'h0001;
         load_done_reg <= (load_cnt_reg == LOAD_CYC - 16'h0001);
      end
   end

   // Sticky notify banks
   sticky_bank #(.W(1)) u_osc (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_event(live_reg.osc_loss),
      .i_mask(mst_osc_mask_reg),
      .i_clear(osc_clr),
      .o_flags(osc_flag)
   );

   sticky_bank #(.W(8)) u_lolho (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_event({live_reg.pll_holdover, live_reg.pll_unlocked}),
      .i_mask(mst_lolho_mask_reg),
      .i_clear(lolho_clr),
      .o_flags(lolho_flags)
   );

   sticky_bank #(.W(4)) u_cl (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_event(live_reg.in_clk_loss),
      .i_mask(mon_cl_mask_reg),
      .i_clear(cl_clr),
      .o_flags(cl_flags)
   );

   sticky_bank #(.W(8)) u_drift (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_event({live_reg.drift_coarse, live_reg.drift_fine}),
      .i_mask(mon_drift_mask_reg),
      .i_clear(drift_clr),
      .o_flags(drift_flags)
   );

   sticky_bank #(.W(4)) u_pll (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_event(live_reg.pll_unlocked),
      .i_mask(pll_lol_mask),
      .i_clear(pll_clr),
      .o_flags(pll_flags)
   );

   // Master runs after the load; power bits go input, monitor, output, PLLs
   assign st_enable[0] = load_done_reg;
   assign st_enable[7:1] = (st[0] == ST_ACTIVE) ?
                           ({power_reg[6:2], power_reg[0], power_reg[1]} | {7{nvm_reg}}) : 7'h00;

   // One state machine per page
   for (genvar g = 0; g < 8; g++) begin : g_fsm
      subsys_state_fsm u_fsm (
         .i_clk(I_CLK),
         .i_reset(I_RESET),
         .i_enable(st_enable[g]),
         .i_auto(nvm_reg),
         .i_commit(commit_vec[g]),
         .o_state(st[g])
      );
   end

   // Readback is only meaningful once the page's select key is written
   assign sel_ok = (sel_reg[pg_idx] == sel_key(pg_idx));

   // Read mux; unmapped offsets and undefined pages read zero, except the page select at FF
   always_comb begin
      rd_next = `BYTE_RST;
      if (addr == `PG_SEL_OFS) begin
         rd_next = page_reg;
      end else if (pg_valid) begin
         if (addr == `STATE_SEL_OFS) begin
            rd_next = sel_reg[pg_idx];
         end else if (addr == `STATE_RD_OFS) begin
            rd_next = sel_ok ? state_code(pg_idx, st[pg_idx]) : `CODE_IDLE;
         end else if (addr == `COMMIT_OFS) begin
            rd_next = `BYTE_RST;
         end else if (on_master) begin
            if (addr == `STICKY_A_OFS) rd_next = {5'h00, osc_flag, 2'h0};
            if (addr == `MASK_A_OFS) rd_next = {5'h00, mst_osc_mask_reg, 2'h0};
            if (addr == `LIVE_B_OFS) rd_next = {live_reg.pll_holdover, live_reg.pll_unlocked};
            if (addr == `STICKY_B_OFS) rd_next = lolho_flags;
            if (addr == `MASK_B_OFS) rd_next = mst_lolho_mask_reg;
            if (addr == `POWER_EN_OFS) rd_next = {1'b0, power_reg};
         end else if (on_monitor) begin
            if (addr == `LIVE_A_OFS) rd_next = {4'h0, live_reg.in_clk_loss};
            if (addr == `STICKY_A_OFS) rd_next = {4'h0, cl_flags};
            if (addr == `MASK_A_OFS) rd_next = {4'h0, mon_cl_mask_reg};
            if (addr == `LIVE_B_OFS) rd_next = {live_reg.drift_coarse, live_reg.drift_fine};
            if (addr == `STICKY_B_OFS) rd_next = drift_flags;
            if (addr == `MASK_B_OFS) rd_next = mon_drift_mask_reg;
         end else if (on_pll) begin
            if (addr == `LIVE_A_OFS) rd_next = {7'h00, live_reg.pll_unlocked[pll_sel]};
            if (addr == `STICKY_A_OFS) rd_next = {7'h00, pll_flags[pll_sel]};
            if (addr == `MASK_A_OFS) rd_next = pll_mask_reg[pll_sel];
         end
      end
   end

   // Read answer one cycle after the request; notify is any sticky flag
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         rd_data_reg <= `BYTE_RST;
         rd_valid_reg <= 1'b0;
         notify_reg <= 1'b0;
      end else begin
         rd_valid_reg <= i_REG_REQ.rd;
         if (i_REG_REQ.rd) rd_data_reg <= rd_next;
         notify_reg <= |{osc_flag, lolho_flags, cl_flags, drift_flags, pll_flags};
      end
   end

   assign o_RD_DATA = rd_data_reg;
   assign o_RD_VALID = rd_valid_reg;
   assign o_NOTIFY = notify_reg;
   assign o_SUBSYS_POWER = power_reg;

endmodule // paged_status_and_init_control
`default_nettype wire

// ### verif/pscr_props.sv
// Port checker for the paged status and init control block
`timescale 1ns/10ps
`default_nettype none
module pscr_props
   import pscr_pkg::*;
(
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RESET,
   // Register port
   input wire reg_req_s i_REG_REQ,
   input wire logic [7:0] o_RD_DATA,
   input wire logic o_RD_VALID,
   // Status side
   input wire live_s i_LIVE,
   input wire logic i_NVM_PROGRAMMED,
   input wire logic o_NOTIFY,
   input wire logic [6:0] o_SUBSYS_POWER
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   logic [7:0] pg_reg;
   logic mask_reg;
   // Page decode of the shadow page
   wire reg_req_s q = i_REG_REQ;
   wire pll_pg = pg_reg inside {[8'h0A:8'h0D]};
   wire undef_pg = !(pg_reg inside {[8'h00:8'h03]}) && !pll_pg;
   wire [1:0] pidx = pg_reg[1:0] - 2'h2;
   wire lol_bit = i_LIVE.pll_unlocked[pidx];
   wire clr_wr = q.wr && (q.addr == 8'h03 || q.addr == 8'h07) && q.wdata != 8'h00;
   wire mask_wr = q.wr && (q.addr == 8'h04 || q.addr == 8'h08) && q.wdata != 8'h00;
   // Shadow page; any nonzero mask write, kept coarse on purpose
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         pg_reg <= 8'h00;
         mask_reg <= 1'b0;
      end else begin
         if (q.wr && q.addr == 8'hFF) pg_reg <= q.wdata;
         if (mask_wr) mask_reg <= 1'b1;
      end
   end
   a_rd_answer: assert property (q.rd |=> o_RD_VALID)
      else $error("read not answered");
   a_no_stray: assert property (!q.rd |=> !o_RD_VALID)
      else $error("read valid without a read");
   a_page_read: assert property (
      q.rd && q.addr == 8'hFF |=> o_RD_DATA == $past(pg_reg))
      else $error("page readback wrong");
   a_undef_zero: assert property (
      q.rd && undef_pg && q.addr != 8'hFF |=> o_RD_DATA == 8'h00)
      else $error("undefined page read not zero");
   a_live_lol: assert property (
      $stable(i_LIVE.pll_unlocked)[*3] ##0 (q.rd && pll_pg && q.addr == 8'h02)
      |=> o_RD_DATA == {7'h00, $past(lol_bit)})
      else $error("live lock loss bit wrong");
   a_notify_mask: assert property (!mask_reg |-> !o_NOTIFY)
      else $error("notify without any mask");
   a_notify_sticky: assert property ($fell(o_NOTIFY) |-> $past(clr_wr, 2))
      else $error("notify dropped without a clear");
   a_notify_cause: assert property ($rose(o_NOTIFY) |-> $past(|i_LIVE, 4))
      else $error("notify rose without an event");
   // Main scenarios
   c_notify: cover property ($rose(o_NOTIFY));
   c_undef: cover property (q.rd && undef_pg);
   c_lol: cover property (q.rd && pll_pg && q.addr == 8'h02 && lol_bit);
endmodule // pscr_props
bind paged_status_and_init_control pscr_props u_pscr_props (.I_CLK(I_CLK),
   .I_RESET(I_RESET), .i_REG_REQ(i_REG_REQ), .o_RD_DATA(o_RD_DATA),
   .o_RD_VALID(o_RD_VALID), .i_LIVE(i_LIVE), .i_NVM_PROGRAMMED(i_NVM_PROGRAMMED),
   .o_NOTIFY(o_NOTIFY), .o_SUBSYS_POWER(o_SUBSYS_POWER));
`default_nettype wire

// ### verif/pscr_host.sv
// Host model driving the register port one access at a time
`timescale 1ns/10ps
`default_nettype none
module pscr_host
   import pscr_pkg::*;
(
   // Clock
   input wire logic I_CLK,
   // Register port
   output var reg_req_s o_req,
   input wire logic [7:0] i_rd_data,
   input wire logic i_rd_valid
);
   initial o_req = '0;
   // Write: held over the taking edge, then released with inverted lines
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge I_CLK);
      o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      @(posedge I_CLK);
   endtask
   // Read: answer sampled one edge after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge I_CLK);
      o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      @(posedge I_CLK);
      d = i_rd_data;
      v = i_rd_valid;
   endtask
endmodule // pscr_host
`default_nettype wire

// ### verif/paged_status_and_init_control_tb.sv
// Self-checking bench for the paged status and init control block
`timescale 1ns/10ps
`default_nettype none
module paged_status_and_init_control_tb
   import pscr_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   live_s live = '0;
   logic nvm = 1'b0;
   reg_req_s req;
   logic [7:0] rdata;
   logic [7:0] d;
   logic rvalid;
   logic notify;
   logic v;
   logic [6:0] power;
   int n_fail = 0;
   int compares = 0;
   // Slave pages in bring-up order, with key, mask and codes
   logic [7:0] pg [7] = '{8'h02, 8'h01, 8'h03, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
   logic [7:0] key [7] = '{8'h40, 8'h40, 8'h60, 8'h20, 8'h20, 8'h20, 8'h20};
   logic [7:0] msk [7] = '{8'h1F, 8'h0F, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0] wcd [7] = '{8'h07, 8'h05, 8'h0C, 8'h08, 8'h08, 8'h08, 8'h08};
   logic [7:0] acd [7] = '{8'h17, 8'h0C, 8'h14, 8'h30, 8'h30, 8'h30, 8'h30};

   paged_status_and_init_control u_paged_status_and_init_control (.I_CLK(clk),
      .I_RESET(rst), .i_REG_REQ(req), .o_RD_DATA(rdata), .o_RD_VALID(rvalid),
      .i_LIVE(live), .i_NVM_PROGRAMMED(nvm), .o_NOTIFY(notify), .o_SUBSYS_POWER(power));
   pscr_host host (.I_CLK(clk), .o_req(req), .i_rd_data(rdata), .i_rd_valid(rvalid));

   initial begin
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Read, then check the valid pulse and the masked data
   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
      host.rd(a, d, v);
      chk({7'h00, v}, 8'h01);
      chk(d & m, exp);
   endtask

   task automatic tally_and_finish;
      $display("compares %0d, n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Whole run is under 1500 cycles; a hang ends the run here
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset page and idle master before the stored load ends
      rchk(8'hFF, 8'hFF, 8'h00);
      host.wr(8'hD1, 8'h40);
      rchk(8'hD0, 8'hFF, 8'h00);
      // Events with every mask still clear must stay silent
      live <= '1;
      repeat (8) @(posedge clk);
      chk({7'h00, notify}, 8'h00);
      live <= '0;
      // Load time, then master waits for the host
      repeat (260) @(posedge clk);
      rchk(8'hD0, 8'hFF, 8'h09);
      // Undefined page keeps its number and reads zero elsewhere
      host.wr(8'hFF, 8'h05);
      rchk(8'hFF, 8'hFF, 8'h05);
      rchk(8'hD0, 8'hFF, 8'h00);
      host.wr(8'hFF, 8'h00);
      host.wr(8'hE1, 8'h7F);
      host.wr(8'hC0, 8'h01);
      rchk(8'hD0, 8'hFF, 8'h24);
      chk({1'b0, power}, 8'h7F);
      // Slaves in order; inputs engaged so input and monitor are set up; PLL B left out
      for (int i = 0; i < 7; i++) begin
         host.wr(8'hFF, pg[i]);
         host.wr(8'hD1, key[i]);
         rchk(8'hD0, msk[i], wcd[i]);
         if (i != 4) begin
            host.wr(8'hC0, 8'h01);
         end
         rchk(8'hD0, msk[i], (i == 4) ? wcd[i] : acd[i]);
      end
      // Dropping the monitor power bit idles the monitor only, not the input
      host.wr(8'hFF, 8'h00);
      host.wr(8'hE1, 8'h7D);
      chk({1'b0, power}, 8'h7D);
      host.wr(8'hFF, 8'h01);
      rchk(8'hD0, 8'h0F, 8'h00);
      host.wr(8'hFF, 8'h02);
      rchk(8'hD0, 8'h1F, 8'h17);
      // Unmask every master and monitor notify, then pulse all events
      host.wr(8'hFF, 8'h00);
      host.wr(8'h04, 8'h04);
      host.wr(8'h08, 8'hFF);
      host.wr(8'hFF, 8'h01);
      host.wr(8'h04, 8'h0F);
      host.wr(8'h08, 8'hFF);
      live <= '1;
      repeat (10) @(posedge clk);
      live <= '0;
      repeat (6) @(posedge clk);
      chk({7'h00, notify}, 8'h01);
      // Three clears plus a zero write leave the oscillator flag up
      host.wr(8'hFF, 8'h00);
      host.wr(8'h03, 8'h00);
      host.wr(8'h07, 8'hFF);
      host.wr(8'hFF, 8'h01);
      host.wr(8'h03, 8'h0F);
      host.wr(8'h07, 8'hFF);
      repeat (3) @(posedge clk);
      chk({7'h00, notify}, 8'h01);
      host.wr(8'hFF, 8'h00);
      host.wr(8'h03, 8'h04);
      repeat (3) @(posedge clk);
      chk({7'h00, notify}, 8'h00);
      // Live lock loss on PLL A follows the pin both ways
      host.wr(8'hFF, 8'h0A);
      host.wr(8'h04, 8'h01);
      live.pll_unlocked <= 4'h1;
      repeat (4) @(posedge clk);
      rchk(8'h02, 8'hFF, 8'h01);
      live.pll_unlocked <= 4'h0;
      repeat (4) @(posedge clk);
      rchk(8'h02, 8'hFF, 8'h00);
      chk({7'h00, notify}, 8'h01);
      // Stored configuration: after a second reset the master wakes straight to active
      nvm <= 1'b1;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({7'h00, notify}, 8'h00);
      host.wr(8'hD1, 8'h40);
      repeat (260) @(posedge clk);
      rchk(8'hD0, 8'hFF, 8'h24);
      tally_and_finish();
   end
endmodule // paged_status_and_init_control_tb
`default_nettype wire
